/* File: hw/pmdb_apb_decode.sv */
`timescale 1ns/1ps
// APB address decode and write strobes for the gate bank
module pmdb_apb_decode
(
   // Request
   input  wire pmdb_pkg::pmdb_apb_req_t i_req,
   // Decode
   output logic [3:0]                   o_hit,
   output logic                         o_wr_stb,
   output logic                         o_mapped
);
   import pmdb_pkg::*;

   always_comb
   begin
      o_hit[0] = (i_req.paddr == PMDB_OFS_CCP);
      o_hit[1] = (i_req.paddr == PMDB_OFS_SPI);
      o_hit[2] = (i_req.paddr == PMDB_OFS_DMA);
      o_hit[3] = (i_req.paddr == PMDB_OFS_CLC);
      o_mapped = |o_hit;
      o_wr_stb = i_req.psel & i_req.penable & i_req.pwrite;
   end
endmodule

/* File: hw/pmdb_bank.sv */
`timescale 1ns/1ps
// How it works
// - Gate register one, bits 3..0 turn off compare units four..one.
// - A one disables the module; zero keeps power and clock on.
// - Serial port register implements only bit 0, turning off port three.
// - Serial port register bits 15..1 always read zero.
// - DMA register bit 5 turns off the upper controller, channels 4-7.
// - DMA register bit 4 turns off the lower controller, channels 0-3.
// - A set DMA bit disables the whole controller; clear keeps it on.
// - Logic cell register bit 3 cell two, bit 2 cell one; bits 1..0 zero.
// - DMA register bits 15..6 and 3..0 always read zero.
module pmdb_bank
(
   // Clock and reset
   input  wire logic                   I_CLK,
   input  wire logic                   I_RST,
   // APB slave
   input  wire logic                   I_PSEL,
   input  wire logic                   I_PENABLE,
   input  wire logic                   I_PWRITE,
   input  wire logic [11:0]            I_PADDR,
   input  wire logic [31:0]            I_PWDATA,
   output logic      [31:0]            O_PRDATA,
   output logic                        O_PREADY,
   output logic                        O_PSLVERR,
   // Peripheral gates, high turns the module off
   output pmdb_pkg::pmdb_gates_t       O_GATES
);
   import pmdb_pkg::*;

   pmdb_apb_req_t req;
   logic [3:0]    hit;
   logic          wr_stb;
   logic          mapped;
   logic [15:0]   val_ccp;
   logic [15:0]   val_spi;
   logic [15:0]   val_dma;
   logic [15:0]   val_clc;
   logic [31:0]   prdata_ff;
   logic [31:0]   nxt_prdata;
   logic          pready_ff;
   logic          pslverr_ff;
   pmdb_gates_t   gates_ff;
   pmdb_gates_t   nxt_gates;
   logic          setup;
   logic          wr_commit;

   assign req.psel    = I_PSEL;
   assign req.penable = I_PENABLE;
   assign req.pwrite  = I_PWRITE;
   assign req.paddr   = I_PADDR;
   assign req.pwdata  = I_PWDATA;

   pmdb_apb_decode u_dec
   (
      .i_req    (req),
      .o_hit    (hit),
      .o_wr_stb (wr_stb),
      .o_mapped (mapped)
   );

   pmdb_gate_reg #(.MASK(PMDB_MASK_CCP)) u_ccp
   (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_we    (wr_commit & hit[0]),
      .i_wdata (I_PWDATA[15:0]),
      .o_value (val_ccp)
   );

   pmdb_gate_reg #(.MASK(PMDB_MASK_SPI)) u_spi
   (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_we    (wr_commit & hit[1]),
      .i_wdata (I_PWDATA[15:0]),
      .o_value (val_spi)
   );

   pmdb_gate_reg #(.MASK(PMDB_MASK_DMA)) u_dma
   (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_we    (wr_commit & hit[2]),
      .i_wdata (I_PWDATA[15:0]),
      .o_value (val_dma)
   );

   pmdb_gate_reg #(.MASK(PMDB_MASK_CLC)) u_clc
   (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_we    (wr_commit & hit[3]),
      .i_wdata (I_PWDATA[15:0]),
      .o_value (val_clc)
   );

   // Setup phase: answer is prepared for the access phase
   assign setup = I_PSEL & ~I_PENABLE;

   // Writes land only at the edge where ready is sampled high
   assign wr_commit = wr_stb & pready_ff;

   // Read mux, upper half and unimplemented bits zero
   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (hit[0])
         nxt_prdata = {16'h0000, val_ccp};
      else if (hit[1])
         nxt_prdata = {16'h0000, val_spi};
      else if (hit[2])
         nxt_prdata = {16'h0000, val_dma};
      else if (hit[3])
         nxt_prdata = {16'h0000, val_clc};
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         prdata_ff <= 32'h0000_0000;
      else if (setup && !I_PWRITE)
         prdata_ff <= nxt_prdata;
   end

   // Ready one cycle after setup, zero wait states in access
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= setup;
         pslverr_ff <= setup & ~mapped;
      end
   end

   // Gate outputs follow stored bits one cycle later
   always_comb
   begin
      nxt_gates.cmp_unit_off       = val_ccp[PMDB_BIT_CMP4:PMDB_BIT_CMP1];
      nxt_gates.serial_port3_off   = val_spi[PMDB_BIT_SPI3];
      nxt_gates.dma_ctrl_upper_off = val_dma[PMDB_BIT_DMA_U];
      nxt_gates.dma_ctrl_lower_off = val_dma[PMDB_BIT_DMA_L];
      nxt_gates.logic_cell2_off    = val_clc[PMDB_BIT_CLC2];
      nxt_gates.logic_cell1_off    = val_clc[PMDB_BIT_CLC1];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         gates_ff <= '0;
      else
         gates_ff <= nxt_gates;
   end

   assign O_PRDATA  = prdata_ff;
   assign O_PREADY  = pready_ff;
   assign O_PSLVERR = pslverr_ff;
   assign O_GATES   = gates_ff;

   // Checks
   sequence wr_done_s(logic [11:0] a);
      I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == a;
   endsequence

   sequence rd_done_s(logic [11:0] a);
      I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY && I_PADDR == a;
   endsequence

   sequence setup_s;
      I_PSEL && !I_PENABLE;
   endsequence

   // Bus timing
   ready_setup_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      setup_s |=> O_PREADY)
      else $error("ready missing after setup");

   ready_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");

   ready_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_PSEL |=> !O_PREADY)
      else $error("ready without select");

   err_ready_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_PSLVERR |-> O_PREADY)
      else $error("error without ready");

   err_unmapped_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && !I_PENABLE && !mapped |=> O_PSLVERR)
      else $error("no error for unmapped address");

   err_mapped_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && !I_PENABLE && mapped |=> !O_PSLVERR)
      else $error("error for mapped address");

   // Gates hold without a write
   ccp_stable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(wr_commit && hit[0]) |-> ##2
      $stable(O_GATES.cmp_unit_off))
      else $error("compare gates changed without write");

   spi_stable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(wr_commit && hit[1]) |-> ##2
      $stable(O_GATES.serial_port3_off))
      else $error("serial port gate changed without write");

   dma_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(wr_commit && hit[2]) |-> ##2
      $stable(O_GATES.dma_ctrl_lower_off))
      else $error("lower dma gate changed without write");

   clc_stable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(wr_commit && hit[3]) |-> ##2
      $stable(O_GATES.logic_cell2_off) &&
      $stable(O_GATES.logic_cell1_off))
      else $error("logic cell gates changed without write");

   err_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_commit && !mapped |-> ##2 $stable(O_GATES))
      else $error("unmapped write changed gates");

   rd_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && I_PENABLE && !I_PWRITE |-> ##2 $stable(O_GATES))
      else $error("read changed gates");

   // Read data, gates following writes, reset clear
   ccp_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      rd_done_s(PMDB_OFS_CCP) |-> O_PRDATA[31:4] == 28'h0 &&
      O_PRDATA[3:0] == O_GATES.cmp_unit_off)
      else $error("compare register read wrong");

   spi_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      rd_done_s(PMDB_OFS_SPI) |->
      O_PRDATA[0] == O_GATES.serial_port3_off)
      else $error("serial port register read wrong");

   dma_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      rd_done_s(PMDB_OFS_DMA) |-> O_PRDATA[5:4] ==
      {O_GATES.dma_ctrl_upper_off, O_GATES.dma_ctrl_lower_off})
      else $error("dma register read wrong");

   clc_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      rd_done_s(PMDB_OFS_CLC) |-> (O_PRDATA & 32'hFFFF_FFF3) == 32'h0 &&
      O_PRDATA[3:2] ==
      {O_GATES.logic_cell2_off, O_GATES.logic_cell1_off})
      else $error("logic cell register read wrong");

   high_half_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY |->
      O_PRDATA[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   err_rdata_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0000_0000)
      else $error("unmapped read data not zero");

   rdata_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
      else $error("read data changed without read");

   ccp_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_done_s(PMDB_OFS_CCP) |-> ##2
      O_GATES.cmp_unit_off == $past(I_PWDATA[3:0], 2))
      else $error("compare gates do not follow write");

   spi_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_done_s(PMDB_OFS_SPI) |-> ##2
      O_GATES.serial_port3_off == $past(I_PWDATA[0], 2))
      else $error("serial port gate does not follow write");

   spi_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == PMDB_OFS_SPI
      |-> O_PRDATA[31:1] == 31'h0)
      else $error("serial port register high bits not zero");

   dma_upper_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_done_s(PMDB_OFS_DMA) |-> ##2
      O_GATES.dma_ctrl_upper_off == $past(I_PWDATA[5], 2))
      else $error("upper dma gate does not follow write");

   dma_lower_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_done_s(PMDB_OFS_DMA) |-> ##2
      O_GATES.dma_ctrl_lower_off == $past(I_PWDATA[4], 2))
      else $error("lower dma gate does not follow write");

   dma_stable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(wr_commit && hit[2]) |-> ##2
      $stable(O_GATES.dma_ctrl_upper_off))
      else $error("dma gate changed without write");

   clc_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_done_s(PMDB_OFS_CLC) |-> ##2
      O_GATES.logic_cell2_off == $past(I_PWDATA[3], 2) &&
      O_GATES.logic_cell1_off == $past(I_PWDATA[2], 2))
      else $error("logic cell gates do not follow write");

   dma_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == PMDB_OFS_DMA
      |-> (O_PRDATA & 32'hFFFF_FFCF) == 32'h0)
      else $error("dma register empty bits not zero");

   reset_clear_a: assert property (@(posedge I_CLK)
      $fell(I_RST) |-> O_GATES == '0)
      else $error("gates not clear after reset");

   // Reset
   rst_gates_a: assert property (@(posedge I_CLK)
      I_RST |=> O_GATES == '0 && !O_PSLVERR)
      else $error("gates or error set during reset");

   rst_bus_a: assert property (@(posedge I_CLK)
      I_RST |=> !O_PREADY && O_PRDATA == 32'h0000_0000)
      else $error("bus outputs set during reset");
endmodule

/* File: hw/pmdb_gate_reg.sv */
`timescale 1ns/1ps
// One masked gate register; only bits set in MASK hold storage
module pmdb_gate_reg
#(
   parameter logic [15:0] MASK = 16'h0000
)
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Write side
   input  wire logic        i_we,
   input  wire logic [15:0] i_wdata,
   // Stored value
   output logic      [15:0] o_value
);
   import pmdb_pkg::*;

   logic [15:0] value_ff;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         value_ff <= PMDB_RST_VAL;
      else if (i_we)
         value_ff <= i_wdata & MASK;
   end

   assign o_value = value_ff & MASK;
endmodule

/* File: shared/pmdb_pkg.sv */
package pmdb_pkg;

   // Register byte offsets on the APB
   localparam logic [11:0] PMDB_OFS_CCP  = 12'h000;
   localparam logic [11:0] PMDB_OFS_SPI  = 12'h004;
   localparam logic [11:0] PMDB_OFS_DMA  = 12'h008;
   localparam logic [11:0] PMDB_OFS_CLC  = 12'h00C;

   // Implemented-bit masks, 16-bit registers
   localparam logic [15:0] PMDB_MASK_CCP = 16'h000F;
   localparam logic [15:0] PMDB_MASK_SPI = 16'h0001;
   localparam logic [15:0] PMDB_MASK_DMA = 16'h0030;
   localparam logic [15:0] PMDB_MASK_CLC = 16'h000C;

   // Field positions
   localparam int PMDB_BIT_CMP1  = 0;
   localparam int PMDB_BIT_CMP4  = 3;
   localparam int PMDB_BIT_SPI3  = 0;
   localparam int PMDB_BIT_DMA_L = 4;
   localparam int PMDB_BIT_DMA_U = 5;
   localparam int PMDB_BIT_CLC1  = 2;
   localparam int PMDB_BIT_CLC2  = 3;

   // Reset value of every gate register
   localparam logic [15:0] PMDB_RST_VAL  = 16'h0000;

   // Number of gate registers
   localparam int PMDB_NUM_REGS = 4;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pmdb_apb_req_t;

   typedef struct packed {
      logic [3:0] cmp_unit_off;
      logic       serial_port3_off;
      logic       dma_ctrl_upper_off;
      logic       dma_ctrl_lower_off;
      logic       logic_cell2_off;
      logic       logic_cell1_off;
   } pmdb_gates_t;

endpackage

/* File: testbench/pmdb_tb.sv */
`timescale 1ns/1ps
module testbench;
   import pmdb_pkg::*;
   logic              clk;
   logic              rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   pmdb_gates_t       gates;
   int                n_fail = 0;
   int                n_checks = 0;
   int                cycles = 0;
   logic [31:0]       q;
   logic              e;
   logic [15:0]       shadow [4];
   logic [11:0]       ofs [4] = '{PMDB_OFS_CCP, PMDB_OFS_SPI,
                                  PMDB_OFS_DMA, PMDB_OFS_CLC};
   logic [15:0]       mask [4] = '{PMDB_MASK_CCP, PMDB_MASK_SPI,
                                   PMDB_MASK_DMA, PMDB_MASK_CLC};

   pmdb_bank uut
   (
      .I_CLK     (clk),
      .I_RST     (rst),
      .I_PSEL    (psel),
      .I_PENABLE (penable),
      .I_PWRITE  (pwrite),
      .I_PADDR   (paddr),
      .I_PWDATA  (pwdata),
      .O_PRDATA  (prdata),
      .O_PREADY  (pready),
      .O_PSLVERR (pslverr),
      .O_GATES   (gates)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask

   // One APB transfer; waits for pready without assuming a latency
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_gates();
      repeat (2) @(posedge clk);
      chk("gates", {23'h0, gates},
          {23'h0, shadow[0][3:0], shadow[1][0], shadow[2][5],
           shadow[2][4], shadow[3][3], shadow[3][2]});
   endtask

   task automatic chk_reads();
      for (int r = 0; r < 4; r++)
      begin
         bus(1'b0, ofs[r], 32'h0000_0000);
         chk("rdata", {16'h0000, shadow[r]}, q);
         chk("err", 32'h0000_0000, {31'h0, e});
      end
   endtask

   task automatic t_reset();
      for (int r = 0; r < 4; r++)
         shadow[r] = 16'h0000;
      chk_gates();
      chk_reads();
   endtask

   task automatic t_walk();
      for (int r = 0; r < 4; r++)
         for (int i = 0; i < 16; i++)
         begin
            bus(1'b1, ofs[r], 32'hA5A5_0000 | (32'h0000_0001 << i));
            shadow[r] = (16'h0001 << i) & mask[r];
            chk_gates();
            bus(1'b0, ofs[r], 32'h0000_0000);
            chk("walk", {16'h0000, shadow[r]}, q);
         end
   endtask

   task automatic t_ones_unmapped();
      for (int r = 0; r < 4; r++)
      begin
         bus(1'b1, ofs[r], 32'hFFFF_FFFF);
         shadow[r] = mask[r];
      end
      chk_gates();
      chk_reads();
      bus(1'b1, 12'h010, 32'h0000_0000);
      chk("wr err", 32'h0000_0001, {31'h0, e});
      chk_gates();
      bus(1'b0, 12'h010, 32'h0000_0000);
      chk("rd err", 32'h0000_0001, {31'h0, e});
      chk("rd bad", 32'h0000_0000, q);
   endtask

   task automatic t_mid_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
   endtask

   initial
   begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_walk();
      t_ones_unmapped();
      t_mid_reset();
      stop_test();
   end
endmodule
